// ==== common/dpbr_pkg.sv ====
/*
 * dpbr_pkg: constants and enumerations for the configurable dual-port
 * block memory. Assumes nothing of its surroundings.
 */
package dpbr_pkg;

    // ************************************************
    // widths and geometry
    // ************************************************
    localparam int ADDR_W      = 16;           // address per port
    localparam int DATA_W      = 32;           // read/write data bus per port
    localparam int PAR_W       = 4;            // parity bus per port
    localparam int WE_W        = 4;            // byte-lane strobes per port
    localparam int WE72_W      = 8;            // strobes in 72-bit simple mode
    localparam int BITS_LOG2   = 15;           // 32768 data bits per block
    localparam int DEPTH_BITS  = 32768;        // data bit cells
    localparam int DEPTH_PBITS = 4096;         // parity bit cells
    localparam int OVL_HI_36   = 14;           // overlap field, 36Kb block
    localparam int OVL_LO_36   = 8;
    localparam int OVL_HI_18   = 13;           // overlap field, 18Kb block
    localparam int OVL_LO_18   = 7;
    localparam int RSTVAL_W    = 36;           // reset value width per port

    // ************************************************
    // configuration encodings
    // ************************************************
    localparam int PIPE_NONE = 0;              // latch output
    localparam int PIPE_ONE  = 1;              // registered output

    // selectable widths
    localparam int W0  = 0;
    localparam int W1  = 1;
    localparam int W2  = 2;
    localparam int W4  = 4;
    localparam int W9  = 9;
    localparam int W18 = 18;
    localparam int W36 = 36;
    localparam int W72 = 72;

    typedef enum logic [1:0] {
        DPBR_WRITE_FIRST = 2'h0,
        DPBR_READ_FIRST  = 2'h1,
        DPBR_NO_CHANGE   = 2'h2
    } dpbr_wmode_e;

    typedef enum logic {
        DPBR_TRUE_TWO_PORT   = 1'h0,
        DPBR_SIMPLE_TWO_PORT = 1'h1
    } dpbr_arrange_e;

    typedef enum logic {
        DPBR_PRIO_RESET = 1'h0,
        DPBR_PRIO_CE    = 1'h1
    } dpbr_prio_e;

    typedef enum logic [1:0] {
        DPBR_CASC_NONE  = 2'h0,
        DPBR_CASC_LOWER = 2'h1,
        DPBR_CASC_UPPER = 2'h2
    } dpbr_casc_e;

    typedef enum logic {
        DPBR_DEFERRED_WRITE = 1'h0,
        DPBR_FULL_SPEED     = 1'h1
    } dpbr_ovl_e;

endpackage

// ==== hw/dpbr_top.sv ====
/*
 * dpbr_top: configurable synchronous dual-port block memory with
 * per-port widths, write behaviours, optional output register, overlap
 * handling, cascade chain and byte-lane strobes.
 * Assumes both ports are driven by logic on core_clk; configuration
 * inputs are held static while enables are active.
 */
`timescale 1ns/1ps

module dpbr_top
    import dpbr_pkg::*;
#(
    parameter int          READ_WIDTH_A  = W36,
    parameter int          READ_WIDTH_B  = W36,
    parameter int          WRITE_WIDTH_A = W36,
    parameter int          WRITE_WIDTH_B = W36,
    parameter int          PIPE_A        = PIPE_NONE,
    parameter int          PIPE_B        = PIPE_NONE,
    parameter dpbr_arrange_e ARRANGE     = DPBR_TRUE_TWO_PORT,
    parameter dpbr_wmode_e WMODE_A       = DPBR_WRITE_FIRST,
    parameter dpbr_wmode_e WMODE_B       = DPBR_WRITE_FIRST,
    parameter dpbr_prio_e  PRIO_A        = DPBR_PRIO_RESET,
    parameter dpbr_prio_e  PRIO_B        = DPBR_PRIO_RESET,
    parameter dpbr_casc_e  CASC_A        = DPBR_CASC_NONE,
    parameter dpbr_casc_e  CASC_B        = DPBR_CASC_NONE,
    parameter dpbr_ovl_e   OVERLAP       = DPBR_DEFERRED_WRITE,
    parameter bit          IS_36K        = 1'b1,
    parameter logic [71:0] RSTVAL_A      = 72'h0,
    parameter logic [RSTVAL_W-1:0] RSTVAL_B = 36'h0
) (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // port A
    input  wire logic                 a_en,
    input  wire logic [WE72_W-1:0]    a_we,
    input  wire logic [ADDR_W-1:0]    a_addr,
    input  wire logic [DATA_W-1:0]    a_write_data_in,
    input  wire logic [PAR_W-1:0]     a_parity_write_in,
    input  wire logic                 a_latch_reset,
    input  wire logic                 a_out_reg_reset,
    input  wire logic                 a_out_reg_clk_en,
    output logic      [DATA_W-1:0]    a_rd_data,
    output logic      [PAR_W-1:0]     a_parity_read_out,
    // port B; in 72-bit simple mode b_write_data_in carries the high word
    input  wire logic                 b_en,
    input  wire logic [WE_W-1:0]      b_we,
    input  wire logic [ADDR_W-1:0]    b_addr,
    input  wire logic [DATA_W-1:0]    b_write_data_in,
    input  wire logic [PAR_W-1:0]     b_parity_write_in,
    input  wire logic                 b_latch_reset,
    input  wire logic                 b_out_reg_reset,
    input  wire logic                 b_out_reg_clk_en,
    output logic      [DATA_W-1:0]    b_rd_data,
    output logic      [PAR_W-1:0]     b_parity_read_out,
    // cascade chain
    input  wire logic                 a_chain_input,
    input  wire logic                 b_chain_input,
    output logic                      a_chain_output,
    output logic                      b_chain_output,
    // overlap status
    output logic                      overlap_seen
);

    // ************************************************
    // memory and helpers
    // ************************************************
    logic [DEPTH_BITS-1:0]  data_mem;
    logic [DEPTH_PBITS-1:0] par_mem;

    // bits per word without parity
    function automatic int dbits(input int w);
        return (w == W9) ? 8 : (w == W18) ? 16 : (w >= W36) ? 32 : w;
    endfunction

    // parity bits per word
    function automatic int pbits(input int w);
        return (w == W9) ? 1 : (w == W18) ? 2 : (w >= W36) ? 4 : 0;
    endfunction

    // low address bits ignored for a width (address counts bits)
    function automatic int lsb(input int w);
        return (w >= W36) ? 5 : (w == W18) ? 4 : (w == W9) ? 3 : (w == W4) ? 2 :
               (w == W2) ? 1 : 0;
    endfunction

    // expand user strobes onto four byte lanes
    function automatic logic [3:0] lanes(input int w, input logic [3:0] we);
        return (w >= W36) ? we : (w == W18) ? {we[1], we[0], we[1], we[0]} : {4{we[0]}};
    endfunction

    // write-first view: strobed lanes show new bytes, the rest old contents
    function automatic logic [DATA_W+PAR_W-1:0] wf_word(input logic [DATA_W+PAR_W-1:0] o,
        input logic [DATA_W-1:0] d, input logic [PAR_W-1:0] p, input logic [3:0] ln);
        logic [DATA_W+PAR_W-1:0] r;
        r = o;
        for (int i = 0; i < 4; i++) if (ln[i]) {r[DATA_W+i], r[8*i+:8]} = {p[i], d[8*i+:8]};
        return r;
    endfunction

    // write one word into the array with strobes
    function automatic logic [DEPTH_BITS-1:0] put_d(input logic [DEPTH_BITS-1:0] m,
        input int w, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d,
        input logic [3:0] ln);
        int base;
        base = int'(ad[BITS_LOG2-1:0]) & ~((1 << lsb(w)) - 1);
        for (int i = 0; i < dbits(w); i++) begin
            if (ln[i/8]) begin
                m[base+i] = d[i];
            end
        end
        return m;
    endfunction

    function automatic logic [DEPTH_PBITS-1:0] put_p(input logic [DEPTH_PBITS-1:0] m,
        input int w, input logic [ADDR_W-1:0] ad, input logic [PAR_W-1:0] p,
        input logic [3:0] ln);
        int base;
        base = int'(ad[BITS_LOG2-1:3]) & ~((1 << (lsb(w) - 3)) - 1);
        for (int i = 0; i < pbits(w); i++) begin
            if (ln[i]) begin
                m[base+i] = p[i];
            end
        end
        return m;
    endfunction

    // read one word, zero above configured width
    function automatic logic [DATA_W+PAR_W-1:0] get_w(input int w,
        input logic [ADDR_W-1:0] ad, input logic [DEPTH_BITS-1:0] m,
        input logic [DEPTH_PBITS-1:0] pm);
        logic [DATA_W+PAR_W-1:0] r;
        int base;
        int pb;
        r = '0;
        base = int'(ad[BITS_LOG2-1:0]) & ~((1 << lsb(w)) - 1);
        pb = base >> 3;
        for (int i = 0; i < dbits(w); i++) begin
            r[i] = m[base+i];
        end
        for (int i = 0; i < pbits(w); i++) begin
            r[DATA_W+i] = pm[pb+i];
        end
        return r;
    endfunction

    // ************************************************
    // decode of enables and overlap
    // ************************************************
    localparam bit SIMPLE = (ARRANGE == DPBR_SIMPLE_TWO_PORT);
    localparam bit WIDE72 = SIMPLE && IS_36K && (WRITE_WIDTH_A == W72 || READ_WIDTH_B == W72);
    localparam bit HAS_RF = (WMODE_A == DPBR_READ_FIRST) || (WMODE_B == DPBR_READ_FIRST);
    localparam bit CASC   = (CASC_A != DPBR_CASC_NONE);
    localparam bit UPPER  = (CASC_A == DPBR_CASC_UPPER);

    logic a_wr;
    logic b_wr;
    logic a_rd;
    logic b_rd;
    logic ovl;
    logic a_sel;
    logic b_sel;

    // cascade half selected by top address bit; one-bit ports
    assign a_sel = !CASC || (a_addr[ADDR_W-1] == UPPER);
    assign b_sel = !CASC || (b_addr[ADDR_W-1] == UPPER);
    // simple mode: A only writes, B only reads
    assign a_wr = a_en && a_sel && (|a_we) && (WRITE_WIDTH_A != W0);
    assign b_wr = b_en && b_sel && (|b_we) && !SIMPLE && (WRITE_WIDTH_B != W0);
    assign a_rd = a_en && !SIMPLE && (READ_WIDTH_A != W0);
    assign b_rd = b_en && (READ_WIDTH_B != W0);
    // overlap field compare
    assign ovl  = HAS_RF && a_en && b_en && (IS_36K ?
                  (a_addr[OVL_HI_36:OVL_LO_36] == b_addr[OVL_HI_36:OVL_LO_36]) :
                  (a_addr[OVL_HI_18:OVL_LO_18] == b_addr[OVL_HI_18:OVL_LO_18]));

    // ************************************************
    // array update
    // ************************************************
    // deferred mode: old contents are sampled into the latches below from
    // the pre-edge array, so reads complete before the write lands
    always_ff @(posedge core_clk) begin
        logic [DEPTH_BITS-1:0]  dm;
        logic [DEPTH_PBITS-1:0] pm;
        dm = data_mem;
        pm = par_mem;
        if (WIDE72 && a_wr) begin
            dm = put_d(dm, W36, {a_addr[ADDR_W-1:6], 6'h00}, a_write_data_in, a_we[3:0]);
            dm = put_d(dm, W36, {a_addr[ADDR_W-1:6], 6'h20}, b_write_data_in, a_we[7:4]);
            pm = put_p(pm, W36, {a_addr[ADDR_W-1:6], 6'h00}, a_parity_write_in, a_we[3:0]);
            pm = put_p(pm, W36, {a_addr[ADDR_W-1:6], 6'h20}, b_parity_write_in, a_we[7:4]);
        end else if (a_wr) begin
            dm = put_d(dm, WRITE_WIDTH_A, a_addr, a_write_data_in, lanes(WRITE_WIDTH_A, a_we[3:0]));
            pm = put_p(pm, WRITE_WIDTH_A, a_addr, a_parity_write_in,
                       lanes(WRITE_WIDTH_A, a_we[3:0]));
        end
        // full speed with overlap drops the port B write while A writes; deferred keeps both writes
        if (b_wr && !(ovl && OVERLAP == DPBR_FULL_SPEED && a_wr)) begin
            dm = put_d(dm, WRITE_WIDTH_B, b_addr, b_write_data_in, lanes(WRITE_WIDTH_B, b_we));
            pm = put_p(pm, WRITE_WIDTH_B, b_addr, b_parity_write_in, lanes(WRITE_WIDTH_B, b_we));
        end
        data_mem <= dm;
        par_mem  <= pm;
    end

    // ************************************************
    // array read latches
    // ************************************************
    logic [DATA_W+PAR_W-1:0] a_latch_reg;
    logic [DATA_W+PAR_W-1:0] b_latch_reg;
    logic [DATA_W+PAR_W-1:0] b_hi_latch_reg;

    // port A latch with write behaviours and latch reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            a_latch_reg <= '0;
        end else if (a_en && a_latch_reset) begin
            a_latch_reg <= {RSTVAL_A[35:32], RSTVAL_A[31:0]};
        end else if (a_rd) begin
            if (!a_wr || WMODE_A == DPBR_READ_FIRST) begin
                a_latch_reg <= get_w(READ_WIDTH_A, a_addr, data_mem, par_mem);
            end else if (WMODE_A == DPBR_WRITE_FIRST) begin
                a_latch_reg <= wf_word(get_w(READ_WIDTH_A, a_addr, data_mem, par_mem),
                                       a_write_data_in, a_parity_write_in,
                                       lanes(WRITE_WIDTH_A, a_we[3:0]));
            end
        end
    end

    // port B latch; in 72-bit mode a second latch holds the high word
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            b_latch_reg    <= '0;
            b_hi_latch_reg <= '0;
        end else if (b_en && b_latch_reset) begin
            b_latch_reg    <= {RSTVAL_B[35:32], RSTVAL_B[31:0]};
            b_hi_latch_reg <= {RSTVAL_A[71:68], RSTVAL_A[67:36]};
        end else if (b_rd) begin
            if (!b_wr || WMODE_B == DPBR_READ_FIRST) begin
                b_latch_reg    <= get_w(WIDE72 ? W36 : READ_WIDTH_B,
                                        WIDE72 ? {b_addr[ADDR_W-1:6], 6'h00} : b_addr,
                                        data_mem, par_mem);
                b_hi_latch_reg <= get_w(W36, {b_addr[ADDR_W-1:6], 6'h20}, data_mem, par_mem);
            end else if (WMODE_B == DPBR_WRITE_FIRST) begin
                b_latch_reg <= wf_word(get_w(READ_WIDTH_B, b_addr, data_mem, par_mem),
                                       b_write_data_in, b_parity_write_in,
                                       lanes(WRITE_WIDTH_B, b_we));
            end
        end
    end

    // cascade: upper block forwards the lower half when its address selects it
    logic [DATA_W+PAR_W-1:0] a_word;
    logic [DATA_W+PAR_W-1:0] b_word;
    logic                    a_csel_reg;
    logic                    b_csel_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            a_csel_reg <= 1'b0;
            b_csel_reg <= 1'b0;
        end else begin
            if (a_en) a_csel_reg <= CASC && UPPER && !a_sel;
            if (b_en) b_csel_reg <= CASC && UPPER && !b_sel;
        end
    end

    assign a_word = a_csel_reg ? {{(DATA_W+PAR_W-1){1'b0}}, a_chain_input} : a_latch_reg;
    assign b_word = b_csel_reg ? {{(DATA_W+PAR_W-1){1'b0}}, b_chain_input} : b_latch_reg;

    // ************************************************
    // optional output registers
    // ************************************************
    logic [DATA_W+PAR_W-1:0] a_out_reg;
    logic [DATA_W+PAR_W-1:0] b_out_reg;

    // port A pipeline register with selectable reset priority
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            a_out_reg <= '0;
        end else if (a_out_reg_reset && (PRIO_A == DPBR_PRIO_RESET || a_out_reg_clk_en)) begin
            a_out_reg <= {RSTVAL_A[35:32], RSTVAL_A[31:0]};
        end else if (a_out_reg_clk_en) begin
            a_out_reg <= a_word;
        end
    end

    // port B pipeline register; in 72-bit mode A output carries the high word
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            b_out_reg <= '0;
        end else if (b_out_reg_reset && (PRIO_B == DPBR_PRIO_RESET || b_out_reg_clk_en)) begin
            b_out_reg <= {RSTVAL_B[35:32], RSTVAL_B[31:0]};
        end else if (b_out_reg_clk_en) begin
            b_out_reg <= b_word;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    logic [DATA_W+PAR_W-1:0] a_sel_out;
    logic [DATA_W+PAR_W-1:0] b_sel_out;

    assign a_sel_out = WIDE72 ? b_hi_latch_reg : (PIPE_A == PIPE_ONE) ? a_out_reg : a_word;
    assign b_sel_out = (PIPE_B == PIPE_ONE) ? b_out_reg : b_word;

    // outputs from flops; latch mode is already registered
    assign a_rd_data         = a_sel_out[DATA_W-1:0];
    assign a_parity_read_out = a_sel_out[DATA_W+PAR_W-1:DATA_W];
    assign b_rd_data         = b_sel_out[DATA_W-1:0];
    assign b_parity_read_out = b_sel_out[DATA_W+PAR_W-1:DATA_W];

    // cascade chain outputs and overlap flag
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            a_chain_output <= 1'b0;
            b_chain_output <= 1'b0;
            overlap_seen   <= 1'b0;
        end else begin
            if (a_en) a_chain_output <= data_mem[a_addr[BITS_LOG2-1:0]];
            if (b_en) b_chain_output <= data_mem[b_addr[BITS_LOG2-1:0]];
            overlap_seen <= ovl;
        end
    end

endmodule // dpbr_top

// ==== sim/dpbr_checker.sv ====
/*
 * dpbr_checker: port-level assertions for dpbr_top, bound to every instance.
 * Assumes port A x36 write-first latch output and port B registered output
 * with clock-enable precedence, as the bench sets them.
 */
`timescale 1ns/1ps

module dpbr_checker
    import dpbr_pkg::*;
#(
    parameter logic [71:0]         RSTVAL_A = 72'h0,
    parameter logic [RSTVAL_W-1:0] RSTVAL_B = 36'h0
) (
    // clock and reset
    input wire logic              core_clk,
    input wire logic              rst,
    // port A
    input wire logic              a_en,
    input wire logic [WE72_W-1:0] a_we,
    input wire logic [ADDR_W-1:0] a_addr,
    input wire logic [DATA_W-1:0] a_write_data_in,
    input wire logic [PAR_W-1:0]  a_parity_write_in,
    input wire logic              a_latch_reset,
    input wire logic [DATA_W-1:0] a_rd_data,
    input wire logic [PAR_W-1:0]  a_parity_read_out,
    // port B and overlap status
    input wire logic              b_en,
    input wire logic [ADDR_W-1:0] b_addr,
    input wire logic              b_out_reg_reset,
    input wire logic              b_out_reg_clk_en,
    input wire logic [DATA_W-1:0] b_rd_data,
    input wire logic [PAR_W-1:0]  b_parity_read_out,
    input wire logic              overlap_seen
);
    logic ovl_cond;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // both ports enabled on the same upper address field
    assign ovl_cond = a_en && b_en
        && (a_addr[OVL_HI_36:OVL_LO_36] == b_addr[OVL_HI_36:OVL_LO_36]);

    a_write_first: assert property (
        a_en && a_we[3:0] == 4'hF && !a_latch_reset |=> a_rd_data == $past(a_write_data_in)
        && a_parity_read_out == $past(a_parity_write_in)) else $error("port A write data not shown");
    a_lane_zero: assert property (
        a_en && a_we[3:0] == 4'h1 && !a_latch_reset |=> a_rd_data[7:0] == $past(a_write_data_in[7:0])
        && a_parity_read_out[0] == $past(a_parity_write_in[0])) else $error("port A lane 0 wrong");
    a_latch_rst: assert property (
        a_en && a_latch_reset |=> {a_parity_read_out, a_rd_data} == RSTVAL_A[35:0])
        else $error("port A latch reset value wrong");
    a_idle_hold: assert property (!a_en |=> $stable(a_rd_data) && $stable(a_parity_read_out))
        else $error("port A output moved while idle");
    a_reg_rst: assert property (
        b_out_reg_reset && b_out_reg_clk_en |=> {b_parity_read_out, b_rd_data} == RSTVAL_B)
        else $error("port B register reset value wrong");
    a_ce_hold: assert property (
        !b_out_reg_clk_en |=> $stable(b_rd_data) && $stable(b_parity_read_out))
        else $error("port B register moved without enable");
    a_ovl_detect: assert property (ovl_cond |=> overlap_seen)
        else $error("overlap missed");
    a_ovl_cause: assert property (overlap_seen |-> $past(ovl_cond))
        else $error("overlap flagged without cause");

    cover property (ovl_cond);
    cover property (b_out_reg_reset && !b_out_reg_clk_en);
    cover property (a_en && a_latch_reset);

endmodule // dpbr_checker

bind dpbr_top dpbr_checker #(.RSTVAL_A(RSTVAL_A), .RSTVAL_B(RSTVAL_B)) u_chk (
    .core_clk(core_clk), .rst(rst), .a_en(a_en), .a_we(a_we), .a_addr(a_addr),
    .a_write_data_in(a_write_data_in), .a_parity_write_in(a_parity_write_in),
    .a_latch_reset(a_latch_reset), .a_rd_data(a_rd_data), .a_parity_read_out(a_parity_read_out),
    .b_en(b_en), .b_addr(b_addr), .b_out_reg_reset(b_out_reg_reset),
    .b_out_reg_clk_en(b_out_reg_clk_en), .b_rd_data(b_rd_data),
    .b_parity_read_out(b_parity_read_out), .overlap_seen(overlap_seen));

// ==== sim/dpbr_fabric.sv ====
/*
 * dpbr_fabric: user logic driving both memory ports, one request per call.
 * Assumes the caller waits for results; idle lines show inverted values.
 */
`timescale 1ns/1ps

module dpbr_fabric
    import dpbr_pkg::*;
(
    // clock
    input wire logic          core_clk,
    // port A
    output logic              a_en,
    output logic [WE72_W-1:0] a_we,
    output logic [ADDR_W-1:0] a_addr,
    output logic [DATA_W-1:0] a_write_data_in,
    output logic [PAR_W-1:0]  a_parity_write_in,
    output logic              a_latch_reset,
    output logic              a_out_reg_reset,
    output logic              a_out_reg_clk_en,
    // port B
    output logic              b_en,
    output logic [WE_W-1:0]   b_we,
    output logic [ADDR_W-1:0] b_addr,
    output logic [DATA_W-1:0] b_write_data_in,
    output logic [PAR_W-1:0]  b_parity_write_in,
    output logic              b_latch_reset,
    output logic              b_out_reg_reset,
    output logic              b_out_reg_clk_en,
    // cascade chain
    output logic              a_chain_input,
    output logic              b_chain_input
);
    // word index to x36 address, bit 15 and low five bits high, bits 14:9 low
    function automatic logic [ADDR_W-1:0] waddr(input logic [3:0] w);
        waddr = {1'b1, 6'h00, w, 5'h1F};
    endfunction

    // quiet ports at time zero; chain inputs tied for non-cascaded use
    initial begin
        {a_en, a_latch_reset, a_out_reg_reset, b_en, b_latch_reset, b_out_reg_reset} = 6'h00;
        {a_chain_input, b_chain_input} = 2'h0;
        {a_out_reg_clk_en, b_out_reg_clk_en} = 2'h3;
        {a_we, b_we, a_parity_write_in, b_parity_write_in} = 20'h00000;
        {a_addr, b_addr} = 32'hFFFFFFFF;
        {a_write_data_in, b_write_data_in} = 64'h0;
    end

    // one request on both ports right after a rising edge
    task automatic drive(input logic ae, input logic [3:0] awe, input logic [3:0] aw,
        input logic [35:0] ad, input logic alr, input logic be, input logic [3:0] bwe,
        input logic [3:0] bw, input logic [35:0] bd, input logic bce, input logic brr);
        @(posedge core_clk);
        a_en <= ae;
        b_en <= be;
        a_latch_reset <= alr;
        b_out_reg_clk_en <= bce;
        b_out_reg_reset <= brr;
        if (ae) begin
            a_we <= {4'h0, awe};
            a_addr <= waddr(aw);
            {a_parity_write_in, a_write_data_in} <= ad;
        end else begin
            a_we <= ~a_we;
            a_addr <= ~a_addr;
            {a_parity_write_in, a_write_data_in} <= ~{a_parity_write_in, a_write_data_in};
        end
        if (be) begin
            b_we <= bwe;
            b_addr <= waddr(bw);
            {b_parity_write_in, b_write_data_in} <= bd;
        end else begin
            b_we <= ~b_we;
            b_addr <= ~b_addr;
            {b_parity_write_in, b_write_data_in} <= ~{b_parity_write_in, b_write_data_in};
        end
    endtask

endmodule // dpbr_fabric

// ==== sim/tb.sv ====
/*
 * tb: self-checking bench for dpbr_top with a reference word model.
 * Assumes the checker is bound by its own file and the fabric drives all inputs except core_clk and rst.
 */
`timescale 1ns/1ps

module tb;
    import dpbr_pkg::*;
    localparam logic [71:0] RV_A = 72'h5_A5A5_0F0F;
    localparam logic [35:0] RV_B = 36'hC_3C3C_F00F;
    logic core_clk, rst, a_en, a_latch_reset, a_out_reg_reset, a_out_reg_clk_en, a_chain_input;
    logic b_en, b_latch_reset, b_out_reg_reset, b_out_reg_clk_en, b_chain_input;
    logic [7:0] a_we;
    logic [3:0] b_we, a_parity_write_in, b_parity_write_in, a_parity_read_out, b_parity_read_out;
    logic [15:0] a_addr, b_addr;
    logic [31:0] a_write_data_in, b_write_data_in, a_rd_data, b_rd_data;
    logic [35:0] mem [16];
    logic [35:0] ma, lb, rb, d0, d1;
    logic [3:0] aw, bw, awe, bwe;
    logic ae, be, alr, bce, brr, bv, lk;
    integer bad_count, n_checks;

    dpbr_top #(.PIPE_B(PIPE_ONE), .WMODE_B(DPBR_READ_FIRST), .PRIO_B(DPBR_PRIO_CE),
        .OVERLAP(DPBR_DEFERRED_WRITE), .RSTVAL_A(RV_A), .RSTVAL_B(RV_B)) dut (
        .core_clk(core_clk), .rst(rst), .a_en(a_en), .a_we(a_we), .a_addr(a_addr),
        .a_write_data_in(a_write_data_in), .a_parity_write_in(a_parity_write_in),
        .a_latch_reset(a_latch_reset), .a_out_reg_reset(a_out_reg_reset),
        .a_out_reg_clk_en(a_out_reg_clk_en), .a_rd_data(a_rd_data),
        .a_parity_read_out(a_parity_read_out), .b_en(b_en), .b_we(b_we), .b_addr(b_addr),
        .b_write_data_in(b_write_data_in), .b_parity_write_in(b_parity_write_in),
        .b_latch_reset(b_latch_reset), .b_out_reg_reset(b_out_reg_reset),
        .b_out_reg_clk_en(b_out_reg_clk_en), .b_rd_data(b_rd_data),
        .b_parity_read_out(b_parity_read_out), .a_chain_input(a_chain_input),
        .b_chain_input(b_chain_input), .a_chain_output(), .b_chain_output(), .overlap_seen());

    dpbr_fabric fab (.core_clk(core_clk), .a_en(a_en), .a_we(a_we), .a_addr(a_addr),
        .a_write_data_in(a_write_data_in), .a_parity_write_in(a_parity_write_in),
        .a_latch_reset(a_latch_reset), .a_out_reg_reset(a_out_reg_reset),
        .a_out_reg_clk_en(a_out_reg_clk_en), .b_en(b_en), .b_we(b_we), .b_addr(b_addr),
        .b_write_data_in(b_write_data_in), .b_parity_write_in(b_parity_write_in),
        .b_latch_reset(b_latch_reset), .b_out_reg_reset(b_out_reg_reset),
        .b_out_reg_clk_en(b_out_reg_clk_en), .a_chain_input(a_chain_input),
        .b_chain_input(b_chain_input));

    // 20 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // word after a byte-lane write: each strobe owns a byte and its parity bit
    function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
        input logic [3:0] we);
        merge = o;
        for (int i = 0; i < 4; i++) if (we[i]) begin
            merge[8*i+:8] = n[8*i+:8];
            merge[32+i] = n[32+i];
        end
    endfunction

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // issue one request pair, compare outputs, then advance the model
    task automatic step();
        if (aw == bw && (awe != 4'h0 || bwe != 4'h0)) be = 1'b0;
        fab.drive(ae, awe, aw, d0, alr, be, bwe, bw, d1, bce, brr);
        @(negedge core_clk);
        chk({a_parity_read_out, a_rd_data}, ma);
        if (bv) chk({b_parity_read_out, b_rd_data}, rb);
        if (bce) begin
            rb = brr ? RV_B : lb;
            bv = brr || lk;
        end
        if (be) lb = mem[bw];
        lk = lk || be;
        if (ae) ma = alr ? RV_A[35:0] : merge(mem[aw], d0, awe);
        if (ae) mem[aw] = merge(mem[aw], d0, awe);
        if (be) mem[bw] = merge(mem[bw], d1, bwe);
    endtask

    // hang guard
    initial begin
        #2000000;
        bad_count++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        {bad_count, n_checks} = 0;
        {ma, rb, lb, bv, lk} = 110'h0;
        void'($urandom(26));
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        // fill every word back to back, B idle
        {be, bwe, bw, d1, alr, bce, brr} = 48'h0;
        for (int w = 0; w < 16; w++) begin
            {ae, awe, aw, d0} = {1'b1, 4'hF, w[3:0], 4'(w), 32'hA5C3_0000 + 32'(w)};
            step();
        end
        // overlap, reset with enable low, then both resets with enable
        {ae, awe, aw, d0, alr, be, bwe, bw, d1, bce, brr} = {1'b1, 4'hF, 4'h3,
            36'hF_1234_5678, 1'b0, 1'b1, 4'h0, 4'h2, 36'h0, 1'b1, 1'b0};
        step();
        {awe, be, bwe, d1, bce, brr} = {4'h0, 1'b1, 4'hF, 36'h9_8765_4321, 1'b0, 1'b1};
        step();
        {alr, bwe, bce} = {1'b1, 4'h0, 1'b1};
        step();
        // random traffic on both ports
        for (int i = 0; i < 600; i++) begin
            aw = 4'($urandom);
            bw = 4'($urandom);
            ae = ($urandom % 4) != 0;
            awe = ($urandom % 2) ? 4'h0 : 4'($urandom);
            alr = ae && awe == 4'h0 && ($urandom % 8) == 0;
            be = ($urandom % 4) != 0;
            bwe = ($urandom % 3) == 0 ? 4'($urandom) : 4'h0;
            bce = ($urandom % 4) != 0;
            brr = ($urandom % 5) == 0;
            d0 = {4'($urandom), 32'($urandom)};
            d1 = {4'($urandom), 32'($urandom)};
            step();
        end
        final_report();
    end

endmodule // tb
